//--- rtl/gpreg_top.v
`include "gpreg_defines.vh"
`default_nettype none
module gpreg_top (
	input wire clk,
	input wire rst,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [7:0] port_a_in,
	input wire [7:0] port_b_in,
	input wire [7:0] port_c_in,
	input wire [7:0] port_d_in,
	input wire [2:0] port_e_in,
	input wire pin_e3_input,
	input wire master_clear_pin_enable,
	output wire [7:0] port_a_out,
	output wire [7:0] port_b_out,
	output wire [7:0] port_c_out,
	output wire [7:0] port_d_out,
	output wire [2:0] port_e_out,
	output wire [7:0] port_a_oe,
	output wire [7:0] port_b_oe,
	output wire [7:0] port_c_oe,
	output wire [7:0] port_d_oe,
	output wire [2:0] port_e_oe,
	output wire [7:0] analog_select_a,
	output wire [7:0] analog_select_b,
	output wire [7:0] analog_select_c,
	output wire [7:0] analog_select_d,
	output wire [2:0] analog_select_e,
	output wire pin_e3_pullup_enable
);
	////////////////////////////////////////////////////////////////////////////
	// Registers
	reg [7:0] lat_a_q;
	reg [7:0] lat_b_q;
	reg [7:0] lat_c_q;
	reg [7:0] lat_d_q;
	reg [7:0] lat_e_q;
	reg [7:0] dir_a_q;
	reg [7:0] dir_b_q;
	reg [7:0] dir_c_q;
	reg [7:0] dir_d_q;
	reg [7:0] dir_e_q;
	reg [7:0] ans_a_q;
	reg [7:0] ans_b_q;
	reg [7:0] ans_c_q;
	reg [7:0] ans_d_q;
	reg [7:0] ans_e_q;
	reg wr_pend_q;
	reg [11:0] wr_addr_q;
	reg [31:0] rdata_q;
	wire [35:0] pins_sync;
	wire [7:0] pin_a;
	wire [7:0] pin_b;
	wire [7:0] pin_c;
	wire [7:0] pin_d;
	wire [7:0] pin_e;
	wire [7:0] wd;
	wire acc;
	reg [7:0] rd_d;

	////////////////////////////////////////////////////////////////////////////
	// Pin sampling
	gpreg_sync #(.W(36)) u_sync (
		.clk(clk),
		.rst(rst),
		.din({pin_e3_input, port_e_in, port_d_in, port_c_in, port_b_in, port_a_in}),
		.dout(pins_sync)
	);

	// Digital input reads zero where analog select is set
	assign pin_a = pins_sync[7:0] & ~ans_a_q;
	assign pin_b = pins_sync[15:8] & ~ans_b_q;
	assign pin_c = pins_sync[23:16] & ~ans_c_q;
	assign pin_d = pins_sync[31:24] & ~ans_d_q;
	// E3 is an input only while the master clear function is off
	assign pin_e = {4'h0, pins_sync[35] & ~master_clear_pin_enable,
		pins_sync[34:32] & ~ans_e_q[2:0]};

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero-wait, always OKAY
	assign acc = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign wd = hwdata[7:0];

	always @* begin
		case (haddr)
			`GPREG_OFS_PIN_A: rd_d = pin_a;
			`GPREG_OFS_PIN_B: rd_d = pin_b;
			`GPREG_OFS_PIN_C: rd_d = pin_c;
			`GPREG_OFS_PIN_D: rd_d = pin_d;
			`GPREG_OFS_PIN_E: rd_d = pin_e & `GPREG_MASK_PIN_E;
			`GPREG_OFS_LAT_A: rd_d = lat_a_q;
			`GPREG_OFS_LAT_B: rd_d = lat_b_q;
			`GPREG_OFS_LAT_C: rd_d = lat_c_q;
			`GPREG_OFS_LAT_D: rd_d = lat_d_q;
			`GPREG_OFS_LAT_E: rd_d = lat_e_q;
			`GPREG_OFS_DIR_A: rd_d = dir_a_q;
			`GPREG_OFS_DIR_B: rd_d = dir_b_q;
			`GPREG_OFS_DIR_C: rd_d = dir_c_q;
			`GPREG_OFS_DIR_D: rd_d = dir_d_q;
			`GPREG_OFS_DIR_E: rd_d = dir_e_q;
			`GPREG_OFS_ANS_A: rd_d = ans_a_q;
			`GPREG_OFS_ANS_B: rd_d = ans_b_q;
			`GPREG_OFS_ANS_C: rd_d = ans_c_q;
			`GPREG_OFS_ANS_D: rd_d = ans_d_q;
			`GPREG_OFS_ANS_E: rd_d = ans_e_q;
			default: rd_d = 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			rdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= acc & hwrite;
			if (acc) begin
				wr_addr_q <= haddr;
			end
			if (acc & ~hwrite) begin
				rdata_q <= {24'h000000, rd_d};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes at the end of the data phase
	always @(posedge clk) begin
		if (rst) begin
			lat_a_q <= `GPREG_RST_LAT;
			lat_b_q <= `GPREG_RST_LAT;
			lat_c_q <= `GPREG_RST_LAT;
			lat_d_q <= `GPREG_RST_LAT;
			lat_e_q <= `GPREG_RST_LAT;
			dir_a_q <= `GPREG_RST_DIR;
			dir_b_q <= `GPREG_RST_DIR;
			dir_c_q <= `GPREG_RST_DIR;
			dir_d_q <= `GPREG_RST_DIR;
			dir_e_q <= `GPREG_RST_DIR & `GPREG_MASK_DIR_E;
			ans_a_q <= `GPREG_RST_ANS & `GPREG_MASK_ANS_A;
			ans_b_q <= `GPREG_RST_ANS & `GPREG_MASK_ANS_B;
			ans_c_q <= `GPREG_RST_ANS & `GPREG_MASK_ANS_C;
			ans_d_q <= `GPREG_RST_ANS & `GPREG_MASK_ANS_D;
			ans_e_q <= `GPREG_RST_ANS & `GPREG_MASK_ANS_E;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				`GPREG_OFS_PIN_A, `GPREG_OFS_LAT_A: lat_a_q <= wd;
				`GPREG_OFS_PIN_B, `GPREG_OFS_LAT_B: lat_b_q <= wd;
				`GPREG_OFS_PIN_C, `GPREG_OFS_LAT_C: lat_c_q <= wd;
				`GPREG_OFS_PIN_D, `GPREG_OFS_LAT_D: lat_d_q <= wd;
				`GPREG_OFS_PIN_E, `GPREG_OFS_LAT_E: lat_e_q <= wd & `GPREG_MASK_LAT_E;
				`GPREG_OFS_DIR_A: dir_a_q <= wd;
				`GPREG_OFS_DIR_B: dir_b_q <= wd;
				`GPREG_OFS_DIR_C: dir_c_q <= wd;
				`GPREG_OFS_DIR_D: dir_d_q <= wd;
				`GPREG_OFS_DIR_E: dir_e_q <= wd & `GPREG_MASK_DIR_E;
				`GPREG_OFS_ANS_A: ans_a_q <= wd & `GPREG_MASK_ANS_A;
				`GPREG_OFS_ANS_B: ans_b_q <= wd & `GPREG_MASK_ANS_B;
				`GPREG_OFS_ANS_C: ans_c_q <= wd & `GPREG_MASK_ANS_C;
				`GPREG_OFS_ANS_D: ans_d_q <= wd & `GPREG_MASK_ANS_D;
				`GPREG_OFS_ANS_E: ans_e_q <= wd & `GPREG_MASK_ANS_E;
				default: lat_a_q <= lat_a_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive: analog select does not touch the output path
	assign port_a_out = lat_a_q;
	assign port_b_out = lat_b_q;
	assign port_c_out = lat_c_q;
	assign port_d_out = lat_d_q;
	assign port_e_out = lat_e_q[2:0];
	assign port_a_oe = ~dir_a_q;
	assign port_b_oe = ~dir_b_q;
	assign port_c_oe = ~dir_c_q;
	assign port_d_oe = ~dir_d_q;
	assign port_e_oe = ~dir_e_q[2:0];
	assign analog_select_a = ans_a_q;
	assign analog_select_b = ans_b_q;
	assign analog_select_c = ans_c_q;
	assign analog_select_d = ans_d_q;
	assign analog_select_e = ans_e_q[2:0];
	assign pin_e3_pullup_enable = dir_e_q[`GPREG_BIT_E_PULLUP];
endmodule // gpreg_top
`default_nettype wire

//--- rtl/gpreg_defines.vh
`ifndef GPREG_DEFINES_VH
`define GPREG_DEFINES_VH
`define GPREG_OFS_PIN_A 12'h000
`define GPREG_OFS_PIN_B 12'h004
`define GPREG_OFS_PIN_C 12'h008
`define GPREG_OFS_PIN_D 12'h00C
`define GPREG_OFS_PIN_E 12'h010
`define GPREG_OFS_LAT_A 12'h014
`define GPREG_OFS_LAT_B 12'h018
`define GPREG_OFS_LAT_C 12'h01C
`define GPREG_OFS_LAT_D 12'h020
`define GPREG_OFS_LAT_E 12'h024
`define GPREG_OFS_DIR_A 12'h028
`define GPREG_OFS_DIR_B 12'h02C
`define GPREG_OFS_DIR_C 12'h030
`define GPREG_OFS_DIR_D 12'h034
`define GPREG_OFS_DIR_E 12'h038
`define GPREG_OFS_ANS_A 12'h03C
`define GPREG_OFS_ANS_B 12'h040
`define GPREG_OFS_ANS_C 12'h044
`define GPREG_OFS_ANS_D 12'h048
`define GPREG_OFS_ANS_E 12'h04C
`define GPREG_MASK_ANS_A 8'h2F
`define GPREG_MASK_ANS_B 8'h3F
`define GPREG_MASK_ANS_C 8'hFC
`define GPREG_MASK_ANS_D 8'hFF
`define GPREG_MASK_ANS_E 8'h07
`define GPREG_MASK_LAT_E 8'h07
`define GPREG_MASK_DIR_E 8'h87
`define GPREG_MASK_PIN_E 8'h0F
`define GPREG_BIT_E_PULLUP 7
`define GPREG_BIT_E3 3
`define GPREG_RST_ANS 8'hFF
`define GPREG_RST_DIR 8'hFF
`define GPREG_RST_LAT 8'h00
`endif

//--- rtl/gpreg_sync.v
`default_nettype none
// Three-stage pin synchroniser; the level changes once stages two and three agree
module gpreg_sync #(
	parameter W = 8
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	always @(posedge clk) begin
		if (rst) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				dout <= s3_q;
			end
		end
	end
endmodule // gpreg_sync
`default_nettype wire

//--- tb/gpreg_sva.sv
`default_nettype none
module gpreg_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe,
	input wire logic [2:0] port_e_oe,
	input wire logic [7:0] analog_select_a,
	input wire logic [7:0] analog_select_b,
	input wire logic [7:0] analog_select_c,
	input wire logic [2:0] analog_select_e,
	input wire logic pin_e3_pullup_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire wr_req = hsel && hready && htrans[1] && hwrite;
	ok_resp_a: assert property (hreadyout && !hresp) else $error("bus not okay");
	ans_rst_a: assert property ($past(rst) |-> analog_select_a == 8'h2F && analog_select_e == 3'h7)
		else $error("analog reset");
	dir_rst_a: assert property ($past(rst) |-> port_a_oe == 8'h00 && port_e_oe == 3'h0)
		else $error("direction reset");
	ans_a_a: assert property (analog_select_a[7:6] == 2'h0 && !analog_select_a[4]) else $error("ans a");
	ans_b_a: assert property (analog_select_b[7:6] == 2'h0) else $error("ans b");
	ans_c_a: assert property (analog_select_c[1:0] == 2'h0) else $error("ans c");
	lat_wr_a: assert property ($changed(port_a_out) |-> $past(wr_req, 2)) else $error("latch moved");
	oe_wr_a: assert property ($changed(port_e_oe) |-> $past(wr_req, 2)) else $error("oe moved");
	pu_wr_a: assert property ($changed(pin_e3_pullup_enable) |-> $past(wr_req, 2)) else $error("pullup");
	ansc_wr_a: assert property ($changed(analog_select_c) |-> $past(wr_req, 2)) else $error("ans moved");
endmodule // gpreg_sva
bind gpreg_top gpreg_sva u_sva (.*);
`default_nettype wire

//--- tb/gpreg_pins.sv
`default_nettype none
module gpreg_pins #(
	parameter int W = 8
) (
	input wire logic [W-1:0] drv,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] ext,
	output logic [W-1:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Driven bits follow the latch, released bits follow the board
	assign pin = (drv & oe) | (ext & ~oe);
endmodule // gpreg_pins
`default_nettype wire

//--- tb/gpreg_top_tb.sv
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module gpreg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] LM [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07};
	localparam logic [7:0] DM [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h87};
	localparam logic [7:0] AM [5] = '{8'h2F, 8'h3F, 8'hFC, 8'hFF, 8'h07};
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, mce = 0, e3_in = 0;
	logic [11:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, rd;
	logic [7:0] ext [5] = '{default: 0};
	logic [7:0] lat [5], dir [5], an [5];
	int n_mismatch = 0, num_checks = 0;
	wire [31:0] hrdata;
	wire hready, hresp, pu;
	wire [7:0] o [5], oe [5], pin [5];
	wire [7:0] ans [5];
	assign o[4][7:3] = 5'h00;
	assign ans[4][7:3] = 5'h00;
	assign oe[4][7:3] = 5'h00;
	always #25 clk = ~clk;
	gpreg_top uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.port_a_in(pin[0]), .port_b_in(pin[1]), .port_c_in(pin[2]), .port_d_in(pin[3]),
		.port_e_in(pin[4][2:0]), .pin_e3_input(e3_in), .master_clear_pin_enable(mce),
		.port_a_out(o[0]), .port_b_out(o[1]), .port_c_out(o[2]), .port_d_out(o[3]), .port_e_out(o[4][2:0]),
		.port_a_oe(oe[0]), .port_b_oe(oe[1]), .port_c_oe(oe[2]), .port_d_oe(oe[3]), .port_e_oe(oe[4][2:0]),
		.analog_select_a(ans[0]), .analog_select_b(ans[1]), .analog_select_c(ans[2]), .analog_select_d(ans[3]),
		.analog_select_e(ans[4][2:0]), .pin_e3_pullup_enable(pu));
	for (genvar k = 0; k < 5; k++) begin : g_pin
		gpreg_pins #(.W(8)) u_pin (.drv(o[k]), .oe(oe[k]), .ext(ext[k]), .pin(pin[k]));
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_rd(input int i);
		int p = i % 5;
		case (i / 5)
			0: exp_rd = ((lat[p] & ~dir[p]) | (ext[p] & dir[p])) & ~an[p] & LM[p]
				| ((p == 4) ? {4'h0, e3_in & ~mce, 3'h0} : 8'h00);
			1: exp_rd = lat[p];
			2: exp_rd = dir[p];
			3: exp_rd = an[p];
			default: exp_rd = 8'h00;
		endcase
	endfunction
	task automatic xfer(input logic w, input int i, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= 12'(i * 4);
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wr_reg(input int i, input logic [31:0] d);
		int p;
		p = i % 5;
		xfer(1'h1, i, d);
		case (i / 5)
			0, 1: lat[p] = d[7:0] & LM[p];
			2: dir[p] = d[7:0] & DM[p];
			3: an[p] = d[7:0] & AM[p];
			default: ;
		endcase
	endtask
	task automatic check;
		@(negedge clk);
		for (int p = 0; p < 5; p++) begin
			`CHK("pin out", lat[p], o[p])
			`CHK("pin oe", ~dir[p] & LM[p], oe[p])
			`CHK("ans", an[p], ans[p])
		end
		`CHK("pullup", dir[4][7], pu)
		for (int i = 0; i < 22; i++) begin
			xfer(1'h0, i, 32'h0);
			`CHK("read", {24'h0, exp_rd(i)}, rd)
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#1000000;
		n_mismatch++;
		final_report;
	end
	initial begin
		void'($urandom(51878));
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		for (int p = 0; p < 5; p++) begin
			lat[p] = 8'h00;
			dir[p] = DM[p];
			an[p] = AM[p];
		end
		repeat (5) @(posedge clk);
		check;
		$display("test reset done");
		repeat (40) begin
			@(posedge clk);
			for (int k = 0; k < 5; k++) ext[k] <= $urandom;
			mce <= $urandom;
			e3_in <= $urandom;
			wr_reg($urandom_range(21), $urandom);
			repeat (5) @(posedge clk);
			check;
		end
		$display("test random done");
		final_report;
	end
endmodule // gpreg_top_tb
`default_nettype wire
